//--- sci_pkg.sv
// Purpose: Shared constants for the sample clock interface block.
// Assumes: Bus clock of 200 MHz; 32-bit register data.
// Notes:   Offsets are byte addresses of aligned 32-bit words.

package sci_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FREQ = 8'h04;
    localparam logic [7:0] OFS_STATE = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h14;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_FORCE_KA = 0;
    localparam int SRC_CLK_OK = 0;
    localparam int SRC_CLK_NOT_OK = 1;
    localparam int SRC_LOCKED = 2;
    localparam int SRC_LOCK_LOST = 3;
    localparam int NUM_SRC = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;
    localparam logic [3:0] IRQ_FLAG_RST = 4'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    // A link clock with no edge for this long is taken as absent.
    localparam int ABSENT_NS = 160;
    localparam int ABSENT_CYC = (ABSENT_NS * 1000) / CLK_PERIOD_PS;
    // Edges that must arrive in a row before the link clock counts as valid.
    localparam int VALID_EDGES = 8;
    // Default length of the reference frequency window in bus cycles.
    localparam int REF_CYC_DEF = 1000;

    // ------------------------------------------------------------------
    // Clock state machine
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_KEEPALIVE = 2'b01,
        ST_GOOD = 2'b10
    } sci_state_e;

endpackage

//--- sci_fifo.sv
// Purpose: Small FIFO carrying frequency counts between counter and register.
// Assumes: Single clock; synchronous active-high reset flushes it.
// Notes:   Read data come out of a register one cycle after the read.

`timescale 1ns/1ps

module sci_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,               // Bus clock.
    input wire logic i_srst,              // Synchronous reset, flushes.
    input wire logic i_wr,                // Push strobe.
    input wire logic [WIDTH-1:0] i_wdata, // Push data.
    input wire logic i_rd,                // Pop strobe.
    output logic [WIDTH-1:0] o_rdata,     // Popped word, one cycle later.
    output logic o_empty,                 // No word stored.
    output logic o_full                   // No room left.
);

    localparam int AW = $clog2(DEPTH);

    // The pointer wrap trick needs a power-of-two depth; others are refused.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("sci_fifo: DEPTH must be a power of two of at least 2.");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    wire do_wr = i_wr && !o_full;
    wire do_rd = i_rd && !o_empty;

    // Flags come straight from the pointers, so they are always honest.
    assign o_empty = (wptr == rptr);
    assign o_full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);

    // Storage needs no reset; only pointers define content.
    always_ff @(posedge i_clk) begin
        if (do_wr) begin
            mem[wptr[AW-1:0]] <= i_wdata;
        end
    end

    // Pointers and registered read data.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wptr <= '0;
            rptr <= '0;
            o_rdata <= '0;
        end else begin
            if (do_wr) begin
                wptr <= wptr + 1'b1;
            end
            if (do_rd) begin
                rptr <= rptr + 1'b1;
                o_rdata <= mem[rptr[AW-1:0]];
            end
        end
    end

endmodule

//--- sci_top.sv
// Purpose: Sample clock interface: keepalive fallback, frequency counting,
//          edge-triggered interrupts and a small register file.
// Assumes: i_link_clk and i_gen_lock are asynchronous to i_clk.
// Notes:   The link clock must be well below half the bus clock rate.

`timescale 1ns/1ps

module sci_top #(
    parameter int REF_CYC = sci_pkg::REF_CYC_DEF, // Reference window length.
    parameter int CNT_W = 32,                     // Frequency count width.
    parameter int FIFO_DEPTH = 4                  // Count FIFO depth.
) (
    input wire logic i_clk,                // Bus clock, 200 MHz.
    input wire logic i_srst,               // Synchronous reset, active high.
    input wire logic [7:0] i_addr,         // Register byte address.
    input wire logic [31:0] i_wdata,       // Register write data.
    input wire logic i_wr,                 // Write strobe.
    input wire logic i_rd,                 // Read strobe.
    output logic [31:0] o_rdata,           // Read data, cycle after i_rd.
    input wire logic i_link_clk,           // Generator clock, asynchronous.
    input wire logic i_gen_lock,           // Generator lock, asynchronous.
    output logic o_sample_clk,             // Sample clock output.
    output logic o_irq,                    // One-cycle interrupt pulse.
    output logic o_irq_lvl                 // High while enabled flag set.
);

    // Sizes the window and count registers cannot serve are refused at elaboration.
    if (REF_CYC < 2 || CNT_W < 8 || CNT_W > 32) begin : g_bad_param
        $error("sci_top: REF_CYC or CNT_W out of range.");
    end

    localparam int NS = sci_pkg::NUM_SRC;
    localparam int ACW = $clog2(sci_pkg::ABSENT_CYC + 1);
    localparam int RCW = $clog2(REF_CYC + 1);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] lclk_sync;
    logic [1:0] lock_sync;
    logic lclk_q;

    // two-flop synchronisers
    // The first stages are read only by the second stages.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            lclk_sync <= 2'b00;
            lock_sync <= 2'b00;
            lclk_q <= 1'b0;
        end else begin
            lclk_sync <= {lclk_sync[0], i_link_clk};
            lock_sync <= {lock_sync[0], i_gen_lock};
            lclk_q <= lclk_sync[1];
        end
    end

    wire lclk_s = lclk_sync[1];
    wire lock_s = lock_sync[1];
    wire lclk_rise = lclk_s && !lclk_q;

    // ------------------------------------------------------------------
    // Link clock presence detection
    // ------------------------------------------------------------------
    logic [ACW-1:0] gap_cnt;
    logic [3:0] edge_run;
    wire link_absent = (gap_cnt >= ACW'(sci_pkg::ABSENT_CYC));
    wire link_valid = (edge_run >= 4'(sci_pkg::VALID_EDGES)) && !link_absent;

    // A run of edges is needed before switching over, so a glitching link
    // cannot bounce the sample clock between sources.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            gap_cnt <= '0;
            edge_run <= 4'h0;
        end else if (lclk_rise) begin
            gap_cnt <= '0;
            if (edge_run < 4'(sci_pkg::VALID_EDGES)) begin
                edge_run <= edge_run + 4'h1;
            end
        end else if (!link_absent) begin
            gap_cnt <= gap_cnt + 1'b1;
        end else begin
            edge_run <= 4'h0;
        end
    end

    // ------------------------------------------------------------------
    // Clock state machine
    // ------------------------------------------------------------------
    sci_pkg::sci_state_e state;
    sci_pkg::sci_state_e next_state;
    logic [31:0] ctrl;
    wire force_ka = ctrl[sci_pkg::CTRL_FORCE_KA];
    wire use_link = link_valid && !force_ka;

    always_comb begin
        next_state = state;
        unique case (state)
            sci_pkg::ST_RESET: begin
                next_state = use_link ? sci_pkg::ST_GOOD : sci_pkg::ST_KEEPALIVE;
            end
            sci_pkg::ST_KEEPALIVE: begin
                if (use_link) begin
                    next_state = sci_pkg::ST_GOOD;
                end
            end
            sci_pkg::ST_GOOD: begin
                if (!use_link) begin
                    next_state = sci_pkg::ST_KEEPALIVE;
                end
            end
            default: begin
                next_state = sci_pkg::ST_RESET;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= sci_pkg::ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Sample clock output
    // ------------------------------------------------------------------
    logic ka_clk;
    wire good = (state == sci_pkg::ST_GOOD);

    // link follows
    // The output is registered so the switch-over never glitches mid-cycle.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ka_clk <= 1'b0;
            o_sample_clk <= 1'b0;
        end else begin
            ka_clk <= !ka_clk;
            o_sample_clk <= good ? lclk_s : ka_clk;
        end
    end

    // ------------------------------------------------------------------
    // Frequency counter and FIFO
    // ------------------------------------------------------------------
    logic [RCW-1:0] ref_cnt;
    logic [CNT_W-1:0] smp_cnt;
    logic [CNT_W-1:0] freq;
    logic fifo_rd_q;
    wire ref_end = (ref_cnt == RCW'(REF_CYC - 1));
    wire fifo_push = ref_end && good;
    wire fifo_empty;
    wire [CNT_W-1:0] fifo_rdata;
    wire fifo_pop = !fifo_empty && !fifo_rd_q;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ref_cnt <= '0;
            smp_cnt <= '0;
        end else begin
            ref_cnt <= ref_end ? '0 : ref_cnt + 1'b1;
            if (ref_end || !good) begin
                smp_cnt <= '0;
            end else if (lclk_rise) begin
                smp_cnt <= smp_cnt + 1'b1;
            end
        end
    end

    sci_fifo #(
        .WIDTH(CNT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_wr(fifo_push),
        .i_wdata(smp_cnt),
        .i_rd(fifo_pop),
        .o_rdata(fifo_rdata),
        .o_empty(fifo_empty),
        .o_full()
    );

    // register load
    // The FIFO is drained one word per two cycles, far faster than it fills.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            fifo_rd_q <= 1'b0;
            freq <= '0;
        end else begin
            fifo_rd_q <= fifo_pop;
            if (fifo_rd_q) begin
                freq <= fifo_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt sources, flags and outputs
    // ------------------------------------------------------------------
    logic lost;
    logic [NS-1:0] src_q;
    logic [NS-1:0] irq_en;
    logic [NS-1:0] flags;
    wire [NS-1:0] src;
    wire [NS-1:0] rise;
    wire [NS-1:0] clr;
    wire wr_en = i_wr && (i_addr == sci_pkg::OFS_IRQ_EN);
    wire wr_flag = i_wr && (i_addr == sci_pkg::OFS_IRQ_FLAG);
    wire wr_ctrl = i_wr && (i_addr == sci_pkg::OFS_CTRL);

    assign src[sci_pkg::SRC_CLK_OK] = good;
    assign src[sci_pkg::SRC_CLK_NOT_OK] = (state == sci_pkg::ST_KEEPALIVE);
    assign src[sci_pkg::SRC_LOCKED] = lock_s;
    assign src[sci_pkg::SRC_LOCK_LOST] = lost;
    assign rise = src & ~src_q;
    assign clr = wr_flag ? i_wdata[NS-1:0] : '0;
    assign o_irq_lvl = |(flags & irq_en);

    // flags reset zero
    // A set in the cycle of a clear wins so no event is lost.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            flags <= sci_pkg::IRQ_FLAG_RST;
        end else begin
            flags <= (flags & ~clr) | rise;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            src_q <= '0;
            lost <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            src_q <= src;
            o_irq <= |(rise & irq_en);
            if (lock_s) begin
                lost <= 1'b0;
            end else if (src_q[sci_pkg::SRC_LOCKED]) begin
                lost <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = sci_pkg::RDATA_ZERO;
        unique case (i_addr)
            sci_pkg::OFS_CTRL: rd_mux = ctrl;
            sci_pkg::OFS_FREQ: rd_mux = 32'(freq);
            sci_pkg::OFS_STATE: rd_mux = {30'h0000_0000, state};
            sci_pkg::OFS_IRQ_EN: rd_mux = {28'h000_0000, irq_en};
            sci_pkg::OFS_IRQ_STAT: rd_mux = {28'h000_0000, src};
            sci_pkg::OFS_IRQ_FLAG: rd_mux = {28'h000_0000, flags};
            default: rd_mux = sci_pkg::RDATA_ZERO;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl <= sci_pkg::CTRL_RST;
            irq_en <= sci_pkg::IRQ_EN_RST;
            o_rdata <= sci_pkg::RDATA_ZERO;
        end else begin
            if (wr_ctrl) begin
                ctrl <= {31'h0000_0000, i_wdata[sci_pkg::CTRL_FORCE_KA]};
            end
            if (wr_en) begin
                irq_en <= i_wdata[NS-1:0];
            end
            o_rdata <= i_rd ? rd_mux : sci_pkg::RDATA_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    sequence s_clk_lost;
        good ##1 !good;
    endsequence

    ka_toggle_a: assert property (!i_srst && !$past(i_srst) |-> ka_clk != $past(ka_clk))
        else $error("Keepalive clock did not toggle.");
    ka_output_a: assert property (!good |=> o_sample_clk == $past(ka_clk))
        else $error("Sample clock not keepalive outside good state.");
    link_follow_a: assert property (good |=> o_sample_clk == $past(lclk_s))
        else $error("Sample clock not following link clock.");
    push_good_a: assert property (fifo_push |-> ##3 freq == $past(smp_cnt, 3))
        else $error("Window count did not reach the frequency register.");
    freq_load_a: assert property (fifo_pop |=> ##1 freq == $past(fifo_rdata))
        else $error("Frequency register not loaded from FIFO.");
    irq_pulse_a: assert property (o_irq |=> !o_irq)
        else $error("Interrupt pulse wider than one cycle.");
    irq_cause_a: assert property (|(rise & irq_en) |=> o_irq)
        else $error("Enabled rising edge gave no interrupt.");
    stat_live_a: assert property (i_rd && i_addr == sci_pkg::OFS_IRQ_STAT
        |=> o_rdata[NS-1:0] == $past(src))
        else $error("Status read not live.");
    flag_hold_a: assert property (flags[0] && !(wr_flag && i_wdata[0])
        |=> flags[0])
        else $error("Flag dropped without a clear.");
    flag_set_a: assert property (rise[1] |=> flags[1])
        else $error("Rising source did not set its flag.");
    no_retrig_a: assert property (src[0] && src_q[0] |=> !o_irq || $past(rise[3:1] != 3'b000))
        else $error("Interrupt without a fresh edge.");
    lost_state_a: assert property (s_clk_lost |-> state == sci_pkg::ST_KEEPALIVE)
        else $error("Good state not left for keepalive.");

endmodule

//--- sci_gen_model.sv
// Purpose: Behavioural model of the external clock generator.
// Assumes: The bench asks for the clock and for lock.
// Notes:   A stopped clock stands low, as a gated generator output does.

`timescale 1ns/1ps

module sci_gen_model #(
    parameter real HALF_NS = 24.0 // Half period of the generated clock.
) (
    input wire logic i_run,  // Run the output clock.
    input wire logic i_lock, // Report lock.
    output logic o_link_clk, // Generated clock.
    output logic o_lock      // Lock indication.
);
    // ----------------------------------------
    // Clock and lock
    // ----------------------------------------
    // The odd start offset keeps the phase unrelated to the bus clock.
    initial begin
        o_link_clk = 1'b0;
        #3.3;
        forever begin
            #(HALF_NS);
            o_link_clk = i_run ? ~o_link_clk : 1'b0;
        end
    end

    // Lock settles a little after the request, like a real loop would.
    // A single continuous driver keeps the lock output free of competing writers.
    assign #20 o_lock = i_lock;
endmodule

//--- sci_top_tb_top.sv
// Purpose: Self-checking bench for the sample clock interface.
// Assumes: Bus clock 5 ns, link clock 48 ns, short reference window.
// Notes:   Random enable values come from a fixed-seed shift register.

`timescale 1ns/1ps

module sci_top_tb_top;
    localparam int REF = 50;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic run = 1'b0;
    logic lock_req = 1'b0;
    logic prev_irq = 1'b0;
    logic [31:0] rdata;
    logic link_clk, gen_lock, sample_clk, irq, irq_lvl;
    logic [31:0] rnd = 32'h0000_15bb;
    int err_count = 0;
    int cmp_count = 0;
    int irq_cnt = 0;

    // ----------------------------------------
    // Design and generator
    // ----------------------------------------
    sci_top #(.REF_CYC(REF)) u_dut (.i_clk(clk), .i_srst(srst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_link_clk(link_clk),
        .i_gen_lock(gen_lock), .o_sample_clk(sample_clk), .o_irq(irq), .o_irq_lvl(irq_lvl));
    sci_gen_model u_gen (.i_run(run), .i_lock(lock_req), .o_link_clk(link_clk),
        .o_lock(gen_lock));

    // Bus clock of 200 MHz.
    initial begin
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0000_0000);
    endfunction

    // Only the four source bits of the enable register are stored.
    function automatic logic [31:0] exp_en(input logic [31:0] d);
        return {28'h000_0000, d[3:0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("Mismatches %0d, comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd_reg(a, d);
        check(d, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Polls the state register; a wait that runs out ends the run.
    task automatic wait_state(input logic [1:0] s);
        logic [31:0] d;
        d = 32'h0000_0000;
        for (int n = 0; n < 400; n++) begin
            rd_reg(sci_pkg::OFS_STATE, d);
            if (d[1:0] === s) break;
        end
        if (d[1:0] !== s) begin
            err_count++;
            $display("BAD t=%0t state wait ran out", $time);
            conclude();
        end
    endtask

    // Counts rising edges of the sample clock over 100 bus cycles.
    task automatic count_sclk(output int n);
        logic last;
        n = 0;
        @(negedge clk);
        last = sample_clk;
        repeat (100) begin
            @(negedge clk);
            if (sample_clk === 1'b1 && last === 1'b0) n++;
            last = sample_clk;
        end
    endtask

    // Interrupt pulses are counted and must never last two cycles.
    always @(negedge clk) begin
        if (prev_irq === 1'b1) check({31'h0, irq}, 32'h0000_0000);
        if (irq === 1'b1) irq_cnt++;
        prev_irq = irq;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int n;
        int base;
        logic [31:0] d;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        cyc(4);
        // Defaults; the not-ok source is live and latched though disabled.
        rd_chk(sci_pkg::OFS_CTRL, sci_pkg::CTRL_RST);
        rd_chk(sci_pkg::OFS_IRQ_EN, 32'h0000_0000);
        rd_chk(sci_pkg::OFS_FREQ, 32'h0000_0000);
        rd_chk(sci_pkg::OFS_STATE, 32'h0000_0001);
        rd_chk(sci_pkg::OFS_IRQ_STAT, 32'h0000_0002);
        rd_chk(sci_pkg::OFS_IRQ_FLAG, 32'h0000_0002);
        rd_chk(8'h40, 32'h0000_0000);
        count_sclk(n);
        check(32'(n), 32'h0000_0032);
        // Clear flags first, then random enables and a read-only write.
        // clear then enable
        wr_reg(sci_pkg::OFS_IRQ_FLAG, 32'h0000_000F);
        rd_chk(sci_pkg::OFS_IRQ_FLAG, 32'h0000_0000);
        repeat (4) begin
            rnd = lfsr(rnd);
            wr_reg(sci_pkg::OFS_IRQ_EN, rnd);
            rd_chk(sci_pkg::OFS_IRQ_EN, exp_en(rnd));
        end
        wr_reg(sci_pkg::OFS_IRQ_STAT, rnd);
        rd_chk(sci_pkg::OFS_IRQ_STAT, 32'h0000_0002);
        wr_reg(sci_pkg::OFS_IRQ_EN, 32'h0000_000F);
        // Lock rises, then the link clock starts.
        base = irq_cnt;
        @(posedge clk);
        lock_req <= 1'b1;
        cyc(20);
        check(32'(irq_cnt - base), 32'h0000_0001);
        rd_chk(sci_pkg::OFS_IRQ_FLAG, 32'h0000_0004);
        run <= 1'b1;
        wait_state(2'd2);
        cyc(5);
        check(32'(irq_cnt - base), 32'h0000_0002);
        rd_chk(sci_pkg::OFS_IRQ_STAT, 32'h0000_0005);
        check({31'h0, irq_lvl}, 32'h0000_0001);
        count_sclk(n);
        check({31'h0, n >= 9 && n <= 12}, 32'h0000_0001);
        cyc(3 * REF);
        rd_reg(sci_pkg::OFS_FREQ, d);
        check({31'h0, d >= 4 && d <= 6}, 32'h0000_0001);
        // Conditions stay high after clearing: no new pulse.
        wr_reg(sci_pkg::OFS_IRQ_FLAG, 32'h0000_000F);
        base = irq_cnt;
        cyc(100);
        check(32'(irq_cnt - base), 32'h0000_0000);
        rd_chk(sci_pkg::OFS_IRQ_FLAG, 32'h0000_0000);
        check({31'h0, irq_lvl}, 32'h0000_0000);
        // Lock lost while masked: flag only, then enabling shows the level.
        wr_reg(sci_pkg::OFS_IRQ_EN, 32'h0000_0000);
        lock_req <= 1'b0;
        cyc(20);
        check(32'(irq_cnt - base), 32'h0000_0000);
        rd_chk(sci_pkg::OFS_IRQ_FLAG, 32'h0000_0008);
        rd_chk(sci_pkg::OFS_IRQ_STAT, 32'h0000_0009);
        wr_reg(sci_pkg::OFS_IRQ_EN, 32'h0000_000F);
        cyc(1);
        check({31'h0, irq_lvl}, 32'h0000_0001);
        // Link clock lost: back to keepalive with one pulse.
        run <= 1'b0;
        wait_state(2'd1);
        cyc(5);
        check(32'(irq_cnt - base), 32'h0000_0001);
        rd_chk(sci_pkg::OFS_IRQ_STAT, 32'h0000_000A);
        rd_chk(sci_pkg::OFS_IRQ_FLAG, 32'h0000_000A);
        count_sclk(n);
        check(32'(n), 32'h0000_0032);
        // Forced keepalive holds the good state off.
        wr_reg(sci_pkg::OFS_CTRL, 32'h0000_0001);
        rd_chk(sci_pkg::OFS_CTRL, 32'h0000_0001);
        run <= 1'b1;
        cyc(200);
        rd_chk(sci_pkg::OFS_STATE, 32'h0000_0001);
        // Reset in mid-run restores the defaults.
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        cyc(4);
        rd_chk(sci_pkg::OFS_CTRL, 32'h0000_0000);
        rd_chk(sci_pkg::OFS_IRQ_EN, 32'h0000_0000);
        rd_chk(sci_pkg::OFS_FREQ, 32'h0000_0000);
        conclude();
    end
endmodule
